// >>> ppfs_cfg.svh
// Operation
// - port 1 bit 7 is comparator one input when all its select conditions hold
// - port 3 bit 0 follows direction unless routed; routed, it drives timer A output when enabled, else is released
// - port 3 bit 3 carries uart2 clear-to-send input or request-to-send output
// - port 3 bit 3 carries serial chip select in or out, optionally open-drain
// - port 3 bit 3 is comparator three input under its select conditions
// - port 3 bit 4 carries timer C channel 3 when routed and serial idle
// - port 3 bit 4 carries serial data in or out; open-drain needs standard mode
// - port 3 bit 4 is comparator three reference input under its conditions
// - two-wire select and enable give SCL and SDA; else channel 4 on bit 5
// - port 3 bit 5 carries serial clock in or out, optionally open-drain
// - port 3 bit 7 drives timer A output when routed there, enabled and unclaimed
// - port 4 bit 5 is irq0, uart2 receive or conversion trigger input
// - port 4 bits 6 and 7 are general ports only with oscillator pin select, crystal mode and stop mode bits clear
// - crystal mode: buffer follows oscillator stop, resistor follows feedback-off bit
// - stop mode turns buffer and feedback resistor off
// - port 6 bit 5 carries uart2 clock in or out, out optionally open-drain
// - port 6 bit 5 carries uart1 clock, else irq4 input when enabled
// - port 6 bit 6 is irq2 input, or uart2 transmit when routed and mode fits
// - pull-up only on undriven pins whose group pull-up bit is set
// - high drive only on driven pins whose group drive bit is set
`ifndef PPFS_CFG_SVH
`define PPFS_CFG_SVH

`define PPFS_NPIN 11
`define PPFS_NGRP 5

// pin positions in the pad vectors
`define PPFS_P1_7 0
`define PPFS_P3_0 1
`define PPFS_P3_3 2
`define PPFS_P3_4 3
`define PPFS_P3_5 4
`define PPFS_P3_7 5
`define PPFS_P4_5 6
`define PPFS_P4_6 7
`define PPFS_P4_7 8
`define PPFS_P6_5 9
`define PPFS_P6_6 10

// pull-up and drive groups
`define PPFS_G_P1H 0
`define PPFS_G_P3L 1
`define PPFS_G_P3H 2
`define PPFS_G_P4 3
`define PPFS_G_P6 4

// field codes
`define PPFS_TA_IO_P17 2'h1
`define PPFS_CS_IN 2'h1
`define PPFS_CS_OFF 2'h0
`define PPFS_SMD_OFF 3'h0
`define PPFS_SMD_CLK 3'h1
`define PPFS_SMD_TX_A 3'h4
`define PPFS_SMD_TX_B 3'h5
`define PPFS_SMD_TX_C 3'h6
`define PPFS_TC_CLK_P33 2'h2
`define PPFS_TC3_P34 2'h2
`define PPFS_TC4_P35 3'h2
`define PPFS_U2CK_P35 2'h1
`define PPFS_ROUTE_11 2'h3
`define PPFS_TX2_P66 3'h5

// reset values
`define PPFS_IN_IDLE 1'b1
`define PPFS_OUT_RST 1'b0
`define PPFS_OE_N_RST 1'b1

`endif

// >>> ppfs_pkg.sv
`include "ppfs_cfg.svh"
package ppfs_pkg;

    typedef struct packed {
        logic [1:0] timer_a_io_route;
        logic timer_a_out_route;
        logic timer_a_out_enable;
        logic irq1_enable;
        logic comparator1_select;
        logic [1:0] chip_select_pin_mode;
        logic chip_select_open_drain;
        logic uart2_handshake_route;
        logic [2:0] serial_mode_field;
        logic handshake_kind_select;
        logic handshake_disable;
        logic irq3_enable;
        logic comparator3_select;
        logic [1:0] timer_c_clock_route;
        logic [1:0] timer_c_ch3_route;
        logic [2:0] timer_c_ch4_route;
        logic two_wire_select;
        logic two_wire_enable;
        logic data_open_drain;
        logic bidirectional_mode;
        logic clock_open_drain;
        logic irq0_enable;
        logic [1:0] uart2_receive_route;
        logic [1:0] conversion_trigger_mode;
        logic oscillator_pin_select;
        logic crystal_mode_bit;
        logic stop_mode_bit;
        logic oscillator_stop_bit;
        logic feedback_resistor_off;
        logic [1:0] uart2_clock_route;
        logic uart2_clock_direction_bit;
        logic uart2_clock_open_drain;
        logic [1:0] uart1_clock_route;
        logic uart1_clock_direction_bit;
        logic [2:0] uart1_mode_field;
        logic irq4_enable;
        logic irq2_route;
        logic irq2_enable;
        logic [2:0] uart2_transmit_route;
        logic uart2_transmit_open_drain;
        logic [`PPFS_NGRP-1:0] pullup_group_bit;
        logic [`PPFS_NGRP-1:0] high_drive_group_bit;
    } ppfs_ctrl_t;

    // values and control strobes from the peripherals
    typedef struct packed {
        logic timer_a_out;
        logic timer_c_ch3_out;
        logic timer_c_ch3_oe;
        logic timer_c_ch4_out;
        logic timer_c_ch4_oe;
        logic serial_chip_select_out;
        logic uart2_request_to_send;
        logic sdi_in_ctl;
        logic sdi_out_ctl;
        logic serial_data_io_out;
        logic sck_in_ctl;
        logic sck_out_ctl;
        logic serial_clock_out;
        logic sdo_in_ctl;
        logic sdo_out_ctl;
        logic serial_data_out;
        logic scl_out;
        logic sda_out;
        logic uart2_clock_out;
        logic uart1_clock_out;
        logic uart2_transmit;
    } ppfs_pout_t;

    // pin levels handed to the peripherals
    typedef struct packed {
        logic timer_c_clock_in;
        logic timer_c_ch3_in;
        logic timer_c_ch4_in;
        logic serial_chip_select_in;
        logic uart2_clear_to_send;
        logic serial_data_io_in;
        logic serial_clock_in;
        logic serial_data_out_in;
        logic scl_in;
        logic sda_in;
        logic ext_irq0_input;
        logic uart2_receive;
        logic conversion_ext_trigger;
        logic ext_irq4_input;
        logic ext_irq2_input;
        logic uart2_clock_in;
        logic uart1_clock_in;
    } ppfs_pin_t;

    typedef struct packed {
        logic comparator1_input;
        logic comparator3_input;
        logic comparator3_reference;
    } ppfs_analog_t;

endpackage

// >>> ppfs_pin_cell.sv
`timescale 1ns/1ns
`include "ppfs_cfg.svh"
module ppfs_pin_cell
    import ppfs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic drive,
    input wire logic value,
    input wire logic open_drain,
    input wire logic pull_req,
    input wire logic high_req,
    output logic pad_out,
    output logic pad_oe_n,
    output logic pull_en,
    output logic high_drive
);
    wire logic oe_next;

    // open-drain releases the pin for a high level
    assign oe_next = drive & ~(open_drain & value);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pad_out <= `PPFS_OUT_RST;
            pad_oe_n <= `PPFS_OE_N_RST;
            pull_en <= 1'b0;
            high_drive <= 1'b0;
        end else begin
            pad_out <= value & ~open_drain;
            pad_oe_n <= ~oe_next;
            pull_en <= pull_req;
            high_drive <= high_req;
        end
    end
endmodule

// >>> ppfs_top.sv
`timescale 1ns/1ns
`include "ppfs_cfg.svh"
module ppfs_top
    import ppfs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire ppfs_pkg::ppfs_ctrl_t ctrl,
    input wire ppfs_pkg::ppfs_pout_t pout,
    input wire logic [`PPFS_NPIN-1:0] pin_dir,
    input wire logic [`PPFS_NPIN-1:0] pin_data,
    input wire logic [`PPFS_NPIN-1:0] pad_in,
    output logic [`PPFS_NPIN-1:0] pad_out,
    output logic [`PPFS_NPIN-1:0] pad_oe_n,
    output logic [`PPFS_NPIN-1:0] pad_pull_en,
    output logic [`PPFS_NPIN-1:0] pad_high_drive,
    output logic [`PPFS_NPIN-1:0] gpio_in,
    output ppfs_pkg::ppfs_pin_t pin_in,
    output ppfs_pkg::ppfs_analog_t analog_sel,
    output logic osc_buffer_on,
    output logic osc_feedback_on
);
    import ppfs_pkg::*;

    function automatic logic is_tx_mode(input logic [2:0] m);
        is_tx_mode = (m == `PPFS_SMD_CLK) || (m == `PPFS_SMD_TX_A) ||
                     (m == `PPFS_SMD_TX_B) || (m == `PPFS_SMD_TX_C);
    endfunction

    function automatic int grp_of(input int p);
        if (p == `PPFS_P1_7) begin
            grp_of = `PPFS_G_P1H;
        end else if (p <= `PPFS_P3_3) begin
            grp_of = `PPFS_G_P3L;
        end else if (p <= `PPFS_P3_7) begin
            grp_of = `PPFS_G_P3H;
        end else if (p <= `PPFS_P4_7) begin
            grp_of = `PPFS_G_P4;
        end else begin
            grp_of = `PPFS_G_P6;
        end
    endfunction

    // per pin: function output, function input claim, value, open-drain, analog
    wire logic [`PPFS_NPIN-1:0] fo;
    wire logic [`PPFS_NPIN-1:0] fi;
    wire logic [`PPFS_NPIN-1:0] fv;
    wire logic [`PPFS_NPIN-1:0] fod;
    wire logic [`PPFS_NPIN-1:0] fan;
    wire logic [`PPFS_NPIN-1:0] drv;
    wire logic [`PPFS_NPIN-1:0] val;

    // port 1 bit 7
    wire logic cmp1_sel;

    // port 3 bit 0
    wire logic ta_p30;

    // port 3 bit 3
    wire logic cs_any;
    wire logic cs_in;
    wire logic cs_out;
    wire logic hs_on;
    wire logic cts_in;
    wire logic rts_out;
    wire logic tcclk_in;
    wire logic cmp3_sel;

    // port 3 bit 4
    wire logic sdi_in;
    wire logic sdi_out;
    wire logic sdi_idle;
    wire logic tc3_sel;
    wire logic tc3_out;
    wire logic cmp3_ref;

    // port 3 bit 5 and 7
    wire logic i2c_on;
    wire logic sck_in;
    wire logic sck_out;
    wire logic sck_free;
    wire logic tc4_sel;
    wire logic tc4_out;
    wire logic sdo_in;
    wire logic sdo_out;
    wire logic sdo_free;
    wire logic ta_p37;

    // port 4
    wire logic rx2_in;
    wire logic irq0_in;
    wire logic trig_in;
    wire logic osc_own;

    // port 6
    wire logic u2ck_sel;
    wire logic u2ck_in;
    wire logic u2ck_out;
    wire logic u1ck_sel;
    wire logic u1ck_in;
    wire logic u1ck_out;
    wire logic irq4_in;
    wire logic tx2_out;
    wire logic irq2_in;

    wire ppfs_pin_t pin_next;
    wire ppfs_analog_t analog_next;
    wire logic buf_next;
    wire logic fb_next;

    assign cmp1_sel = ~pin_dir[`PPFS_P1_7] &
                      (ctrl.timer_a_io_route != `PPFS_TA_IO_P17) &
                      ctrl.irq1_enable & ctrl.comparator1_select;
    assign fo[`PPFS_P1_7] = 1'b0;
    assign fi[`PPFS_P1_7] = cmp1_sel;
    assign fv[`PPFS_P1_7] = 1'b0;
    assign fod[`PPFS_P1_7] = 1'b0;
    assign fan[`PPFS_P1_7] = cmp1_sel;

    assign ta_p30 = ctrl.timer_a_out_route & ctrl.timer_a_out_enable;
    assign fo[`PPFS_P3_0] = ta_p30;
    // routed but not enabled: released rather than general port
    assign fi[`PPFS_P3_0] = ctrl.timer_a_out_route & ~ctrl.timer_a_out_enable;
    assign fv[`PPFS_P3_0] = pout.timer_a_out;
    assign fod[`PPFS_P3_0] = 1'b0;
    assign fan[`PPFS_P3_0] = 1'b0;

    // chip select wins over the others
    assign cs_any = ctrl.chip_select_pin_mode != `PPFS_CS_OFF;
    assign cs_in = ctrl.chip_select_pin_mode == `PPFS_CS_IN;
    assign cs_out = ctrl.chip_select_pin_mode[1];
    assign hs_on = ~cs_any & ctrl.uart2_handshake_route &
                   (ctrl.serial_mode_field != `PPFS_SMD_OFF) & ~ctrl.handshake_disable;
    assign cts_in = hs_on & ~ctrl.handshake_kind_select & ~pin_dir[`PPFS_P3_3];
    assign rts_out = hs_on & ctrl.handshake_kind_select;
    assign tcclk_in = ~cs_any & ~ctrl.uart2_handshake_route & ~pin_dir[`PPFS_P3_3] &
                      (ctrl.timer_c_clock_route == `PPFS_TC_CLK_P33);
    assign cmp3_sel = ~cs_any & ~ctrl.uart2_handshake_route & ~pin_dir[`PPFS_P3_3] &
                      ctrl.irq3_enable & ctrl.comparator3_select &
                      (ctrl.timer_c_clock_route != `PPFS_TC_CLK_P33);
    // chip select, then handshake, then timer clock, then comparator
    assign fo[`PPFS_P3_3] = cs_out | rts_out;
    assign fi[`PPFS_P3_3] = cs_in | cts_in | tcclk_in | cmp3_sel;
    assign fv[`PPFS_P3_3] = cs_out ? pout.serial_chip_select_out : pout.uart2_request_to_send;
    assign fod[`PPFS_P3_3] = cs_out & ctrl.chip_select_open_drain;
    assign fan[`PPFS_P3_3] = cmp3_sel;

    assign sdi_out = ~ctrl.two_wire_select & pout.sdi_out_ctl;
    assign sdi_in = ~ctrl.two_wire_select & pout.sdi_in_ctl & ~pout.sdi_out_ctl;
    assign sdi_idle = ~pout.sdi_in_ctl & ~pout.sdi_out_ctl;
    assign tc3_sel = sdi_idle & (ctrl.timer_c_ch3_route == `PPFS_TC3_P34);
    assign tc3_out = tc3_sel & pout.timer_c_ch3_oe;
    assign cmp3_ref = ~pin_dir[`PPFS_P3_4] & sdi_idle &
                      (ctrl.timer_c_ch3_route != `PPFS_TC3_P34) & ctrl.comparator3_select;
    assign fo[`PPFS_P3_4] = sdi_out | tc3_out;
    assign fi[`PPFS_P3_4] = sdi_in | tc3_sel | cmp3_ref;
    assign fv[`PPFS_P3_4] = sdi_out ? pout.serial_data_io_out : pout.timer_c_ch3_out;
    assign fod[`PPFS_P3_4] = sdi_out & ctrl.data_open_drain & ~ctrl.bidirectional_mode;
    assign fan[`PPFS_P3_4] = cmp3_ref;

    assign i2c_on = ctrl.two_wire_select & ctrl.two_wire_enable;
    assign sck_out = ~ctrl.two_wire_select & pout.sck_out_ctl;
    assign sck_in = ~ctrl.two_wire_select & pout.sck_in_ctl & ~pout.sck_out_ctl;
    assign sck_free = ctrl.two_wire_select ? ~ctrl.two_wire_enable :
                      (~pout.sck_in_ctl & ~pout.sck_out_ctl);
    // channel 4 when two-wire is off
    assign tc4_sel = sck_free & (ctrl.timer_c_ch4_route == `PPFS_TC4_P35) &
                     (ctrl.uart2_clock_route != `PPFS_U2CK_P35);
    assign tc4_out = tc4_sel & pout.timer_c_ch4_oe;
    assign fo[`PPFS_P3_5] = i2c_on | sck_out | tc4_out;
    assign fi[`PPFS_P3_5] = sck_in | tc4_sel;
    assign fv[`PPFS_P3_5] = i2c_on ? pout.scl_out :
                            sck_out ? pout.serial_clock_out : pout.timer_c_ch4_out;
    assign fod[`PPFS_P3_5] = i2c_on | (sck_out & ctrl.clock_open_drain);
    assign fan[`PPFS_P3_5] = 1'b0;

    assign sdo_out = ~ctrl.two_wire_select & pout.sdo_out_ctl;
    assign sdo_in = ~ctrl.two_wire_select & pout.sdo_in_ctl & ~pout.sdo_out_ctl;
    assign sdo_free = ctrl.two_wire_select ? ~ctrl.two_wire_enable :
                      (~pout.sdo_in_ctl & ~pout.sdo_out_ctl);
    assign ta_p37 = sdo_free & ~ctrl.timer_a_out_route & ctrl.timer_a_out_enable;
    assign fo[`PPFS_P3_7] = i2c_on | sdo_out | ta_p37;
    assign fi[`PPFS_P3_7] = sdo_in;
    assign fv[`PPFS_P3_7] = i2c_on ? pout.sda_out :
                            sdo_out ? pout.serial_data_out : pout.timer_a_out;
    assign fod[`PPFS_P3_7] = i2c_on | (sdo_out & ctrl.data_open_drain);
    assign fan[`PPFS_P3_7] = 1'b0;

    assign rx2_in = ~pin_dir[`PPFS_P4_5] & (ctrl.uart2_receive_route == `PPFS_ROUTE_11);
    assign irq0_in = ~pin_dir[`PPFS_P4_5] & ctrl.irq0_enable &
                     (ctrl.uart2_receive_route != `PPFS_ROUTE_11);
    assign trig_in = irq0_in & ctrl.conversion_trigger_mode[1];
    assign fo[`PPFS_P4_5] = 1'b0;
    assign fi[`PPFS_P4_5] = rx2_in | irq0_in;
    assign fv[`PPFS_P4_5] = 1'b0;
    assign fod[`PPFS_P4_5] = 1'b0;
    assign fan[`PPFS_P4_5] = 1'b0;

    // oscillator owns bits 6 and 7
    assign osc_own = ctrl.oscillator_pin_select | ctrl.crystal_mode_bit | ctrl.stop_mode_bit;
    assign fo[`PPFS_P4_7:`PPFS_P4_6] = 2'h0;
    assign fi[`PPFS_P4_7:`PPFS_P4_6] = {2{osc_own}};
    assign fv[`PPFS_P4_7:`PPFS_P4_6] = 2'h0;
    assign fod[`PPFS_P4_7:`PPFS_P4_6] = 2'h0;
    assign fan[`PPFS_P4_7:`PPFS_P4_6] = {2{osc_own}};
    assign buf_next = ctrl.crystal_mode_bit & ~ctrl.stop_mode_bit & ~ctrl.oscillator_stop_bit;
    assign fb_next = ctrl.crystal_mode_bit & ~ctrl.stop_mode_bit & ~ctrl.feedback_resistor_off;

    assign u2ck_sel = ctrl.uart2_clock_route == `PPFS_ROUTE_11;
    assign u2ck_in = u2ck_sel & ctrl.uart2_clock_direction_bit & ~pin_dir[`PPFS_P6_5];
    assign u2ck_out = u2ck_sel & ~ctrl.uart2_clock_direction_bit &
                      (ctrl.serial_mode_field == `PPFS_SMD_CLK);
    assign u1ck_sel = ~u2ck_sel & (ctrl.uart1_clock_route == `PPFS_ROUTE_11);
    assign u1ck_in = u1ck_sel & ctrl.uart1_clock_direction_bit & ~pin_dir[`PPFS_P6_5];
    assign u1ck_out = u1ck_sel & ~ctrl.uart1_clock_direction_bit &
                      (ctrl.uart1_mode_field == `PPFS_SMD_CLK);
    assign irq4_in = ~u2ck_sel & ~u1ck_sel & ctrl.irq4_enable & ~pin_dir[`PPFS_P6_5];
    assign fo[`PPFS_P6_5] = u2ck_out | u1ck_out;
    assign fi[`PPFS_P6_5] = u2ck_in | u1ck_in | irq4_in;
    assign fv[`PPFS_P6_5] = u2ck_out ? pout.uart2_clock_out : pout.uart1_clock_out;
    assign fod[`PPFS_P6_5] = u2ck_out & ctrl.uart2_clock_open_drain;
    assign fan[`PPFS_P6_5] = 1'b0;

    assign tx2_out = (ctrl.uart2_transmit_route == `PPFS_TX2_P66) &
                     is_tx_mode(ctrl.serial_mode_field);
    assign irq2_in = ~ctrl.irq2_route & ctrl.irq2_enable & ~pin_dir[`PPFS_P6_6] &
                     (ctrl.uart2_transmit_route != `PPFS_TX2_P66);
    assign fo[`PPFS_P6_6] = tx2_out;
    assign fi[`PPFS_P6_6] = irq2_in;
    assign fv[`PPFS_P6_6] = pout.uart2_transmit;
    assign fod[`PPFS_P6_6] = tx2_out & ctrl.uart2_transmit_open_drain;
    assign fan[`PPFS_P6_6] = 1'b0;

    // function output first, claimed input next, then port bits
    assign drv = fo | (~fi & pin_dir);
    assign val = (fo & fv) | (~fo & pin_data);

    genvar g;
    generate
        for (g = 0; g < `PPFS_NPIN; g++) begin : g_pin
            wire logic pull_req;
            wire logic high_req;
            assign pull_req = ~drv[g] & ~fan[g] & ctrl.pullup_group_bit[grp_of(g)];
            assign high_req = drv[g] & ctrl.high_drive_group_bit[grp_of(g)];
            ppfs_pin_cell u_cell (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .drive(drv[g]),
                .value(val[g]),
                .open_drain(fod[g]),
                .pull_req(pull_req),
                .high_req(high_req),
                .pad_out(pad_out[g]),
                .pad_oe_n(pad_oe_n[g]),
                .pull_en(pad_pull_en[g]),
                .high_drive(pad_high_drive[g])
            );
        end
    endgenerate

    // unselected inputs read as the idle level
    assign pin_next = '{
        timer_c_clock_in: tcclk_in ? pad_in[`PPFS_P3_3] : `PPFS_IN_IDLE,
        timer_c_ch3_in: tc3_sel ? pad_in[`PPFS_P3_4] : `PPFS_IN_IDLE,
        timer_c_ch4_in: tc4_sel ? pad_in[`PPFS_P3_5] : `PPFS_IN_IDLE,
        serial_chip_select_in: cs_in ? pad_in[`PPFS_P3_3] : `PPFS_IN_IDLE,
        uart2_clear_to_send: cts_in ? pad_in[`PPFS_P3_3] : `PPFS_IN_IDLE,
        serial_data_io_in: sdi_in ? pad_in[`PPFS_P3_4] : `PPFS_IN_IDLE,
        serial_clock_in: sck_in ? pad_in[`PPFS_P3_5] : `PPFS_IN_IDLE,
        serial_data_out_in: sdo_in ? pad_in[`PPFS_P3_7] : `PPFS_IN_IDLE,
        scl_in: i2c_on ? pad_in[`PPFS_P3_5] : `PPFS_IN_IDLE,
        sda_in: i2c_on ? pad_in[`PPFS_P3_7] : `PPFS_IN_IDLE,
        ext_irq0_input: irq0_in ? pad_in[`PPFS_P4_5] : `PPFS_IN_IDLE,
        uart2_receive: rx2_in ? pad_in[`PPFS_P4_5] : `PPFS_IN_IDLE,
        conversion_ext_trigger: trig_in ? pad_in[`PPFS_P4_5] : `PPFS_IN_IDLE,
        ext_irq4_input: irq4_in ? pad_in[`PPFS_P6_5] : `PPFS_IN_IDLE,
        ext_irq2_input: irq2_in ? pad_in[`PPFS_P6_6] : `PPFS_IN_IDLE,
        uart2_clock_in: u2ck_in ? pad_in[`PPFS_P6_5] : `PPFS_IN_IDLE,
        uart1_clock_in: u1ck_in ? pad_in[`PPFS_P6_5] : `PPFS_IN_IDLE
    };

    assign analog_next = '{
        comparator1_input: cmp1_sel,
        comparator3_input: cmp3_sel,
        comparator3_reference: cmp3_ref
    };

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pin_in <= '{default: `PPFS_IN_IDLE};
            analog_sel <= '0;
            gpio_in <= '0;
            osc_buffer_on <= 1'b0;
            osc_feedback_on <= 1'b0;
        end else begin
            pin_in <= pin_next;
            analog_sel <= analog_next;
            gpio_in <= pad_in;
            osc_buffer_on <= buf_next;
            osc_feedback_on <= fb_next;
        end
    end
endmodule

// >>> ppfs_assertions.sv
`timescale 1ns/1ns
module ppfs_assertions
    import ppfs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire ppfs_pkg::ppfs_ctrl_t ctrl,
    input wire ppfs_pkg::ppfs_pout_t pout,
    input wire logic [10:0] pin_dir,
    input wire logic [10:0] pad_in,
    input wire logic [10:0] pad_out,
    input wire logic [10:0] pad_oe_n,
    input wire logic [10:0] pad_pull_en,
    input wire logic [10:0] pad_high_drive,
    input wire ppfs_pkg::ppfs_pin_t pin_in,
    input wire logic osc_buffer_on,
    input wire logic osc_feedback_on
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // outputs lag the inputs by one edge; skip the edge after reset
    sequence s_live;
        $past(resetn);
    endsequence
    sequence s_i2c;
        s_live ##0 $past(ctrl.two_wire_select && ctrl.two_wire_enable);
    endsequence
    a_stop_all_off: assert property (s_live ##0 $past(ctrl.stop_mode_bit)
        |-> !osc_buffer_on && !osc_feedback_on) else $error("osc on in stop");
    a_crystal_osc: assert property (s_live ##0
        $past(ctrl.crystal_mode_bit && !ctrl.stop_mode_bit)
        |-> osc_buffer_on == !$past(ctrl.oscillator_stop_bit)
        && osc_feedback_on == !$past(ctrl.feedback_resistor_off)) else $error("osc ctl");
    a_osc_pins_held: assert property (s_live ##0 $past(ctrl.oscillator_pin_select
        || ctrl.crystal_mode_bit || ctrl.stop_mode_bit) |-> pad_oe_n[8:7] == 2'h3)
        else $error("osc pin driven");
    a_timer_a_out: assert property (s_live ##0
        $past(ctrl.timer_a_out_route && ctrl.timer_a_out_enable)
        |-> !pad_oe_n[1] && pad_out[1] == $past(pout.timer_a_out)) else $error("p30 out");
    a_i2c_scl_od: assert property (s_i2c
        |-> !pad_out[4] && pad_oe_n[4] == $past(pout.scl_out)) else $error("scl");
    a_rx2_route: assert property (s_live ##0
        $past(ctrl.uart2_receive_route == 2'h3 && !pin_dir[6])
        |-> pin_in.uart2_receive == $past(pad_in[6])) else $error("rx2 in");
    a_pull_gate: assert property (s_live ##0 pad_pull_en[2]
        |-> $past(ctrl.pullup_group_bit[1]) && pad_oe_n[2]) else $error("pull");
    a_high_drive: assert property (s_live ##0
        $past(ctrl.high_drive_group_bit[1]) && !pad_oe_n[1] |-> pad_high_drive[1])
        else $error("drive");
endmodule
bind ppfs_top ppfs_assertions u_chk (.ref_clk, .resetn, .ctrl, .pout, .pin_dir,
    .pad_in, .pad_out, .pad_oe_n, .pad_pull_en, .pad_high_drive, .pin_in,
    .osc_buffer_on, .osc_feedback_on);

// >>> ppfs_pads.sv
`timescale 1ns/1ns
module ppfs_pads (
    input wire logic ref_clk,
    input wire logic [10:0] pad_out,
    input wire logic [10:0] pad_oe_n,
    input wire logic [10:0] pad_pull_en,
    input wire logic [10:0] ext_en,
    input wire logic [10:0] ext_val,
    output logic [10:0] pad_in
);
    logic [10:0] last_reg;
    // a floating pin wanders away from its last level
    always_comb begin
        for (int i = 0; i < 11; i++) begin
            pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                pad_pull_en[i] ? 1'b1 : ~last_reg[i];
        end
    end
    always_ff @(posedge ref_clk) begin
        last_reg <= pad_in;
    end
endmodule

// >>> ppfs_tb_top.sv
`timescale 1ns/1ns
module ppfs_tb_top;
    import ppfs_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    ppfs_ctrl_t ctrl = '0;
    ppfs_pout_t pout = '0;
    logic [10:0] pin_dir = '0, pin_data = '0, ext_en = '0, ext_val = '0;
    logic [10:0] pad_in, pad_out, pad_oe_n, pad_pull_en, pad_high_drive, gpio_in;
    ppfs_pin_t pin_in;
    ppfs_analog_t analog_sel;
    logic osc_buffer_on, osc_feedback_on;
    int failures = 0;
    int checked = 0;
    int i;
    always #4 ref_clk = ~ref_clk;
    ppfs_top u_dut (.ref_clk, .resetn, .ctrl, .pout, .pin_dir, .pin_data, .pad_in,
        .pad_out, .pad_oe_n, .pad_pull_en, .pad_high_drive, .gpio_in, .pin_in,
        .analog_sel, .osc_buffer_on, .osc_feedback_on);
    ppfs_pads u_pads (.ref_clk, .pad_out, .pad_oe_n, .pad_pull_en, .ext_en, .ext_val,
        .pad_in);
    task automatic chkv(input logic [10:0] got, input logic [10:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t vec got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic go;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        stop_test;
    end
    initial begin
        repeat (5) @(negedge ref_clk);
        chkv(pad_oe_n, 11'h7FF);
        resetn = 1'b1;
        ctrl.pullup_group_bit = 5'h1D;
        ctrl.high_drive_group_bit = 5'h1E;
        pin_dir = 11'h7FF;
        pin_data = 11'h2A5;
        go;
        chkv(pad_out, 11'h2A5);
        chkv(pad_high_drive, 11'h7FE);
        pin_dir = 11'h0;
        go;
        chkv(pad_oe_n, 11'h7FF);
        chkv(pad_pull_en, 11'h7F9);
        chkv(gpio_in, 11'h2A5);
        ctrl.timer_a_out_route = 1'b1;
        ctrl.timer_a_out_enable = 1'b1;
        pout.timer_a_out = 1'b1;
        go;
        chk1(pad_oe_n[1], 1'b0);
        chk1(pad_out[1], 1'b1);
        ctrl.timer_a_out_enable = 1'b0;
        go;
        chk1(pad_oe_n[1], 1'b1);
        ctrl.timer_a_out_route = 1'b0;
        ctrl.timer_a_out_enable = 1'b1;
        go;
        chk1(pad_oe_n[5], 1'b0);
        chk1(pad_out[5], 1'b1);
        ctrl.two_wire_select = 1'b1;
        ctrl.two_wire_enable = 1'b1;
        pout.scl_out = 1'b1;
        ext_en = 11'h050;
        go;
        chk1(pad_oe_n[5], 1'b0);
        chk1(pad_out[5], 1'b0);
        chk1(pad_oe_n[4], 1'b1);
        chk1(pin_in.scl_in, 1'b0);
        pin_dir = 11'h7FF;
        for (i = 0; i < 16; i++) begin
            ctrl = '0;
            {ctrl.crystal_mode_bit, ctrl.stop_mode_bit, ctrl.oscillator_stop_bit,
                ctrl.feedback_resistor_off} = 4'(i);
            go;
            chk1(osc_buffer_on, i[3] & ~i[2] & ~i[1]);
            chk1(osc_feedback_on, i[3] & ~i[2] & ~i[0]);
            chk1(pad_oe_n[7], i[3] | i[2]);
        end
        pin_dir = 11'h0;
        ctrl = '0;
        ctrl.irq1_enable = 1'b1;
        ctrl.comparator1_select = 1'b1;
        ctrl.pullup_group_bit = 5'h1F;
        ctrl.uart2_receive_route = 2'h3;
        go;
        chk1(analog_sel.comparator1_input, 1'b1);
        chk1(pad_pull_en[0], 1'b0);
        chk1(pin_in.uart2_receive, 1'b0);
        chk1(pin_in.ext_irq0_input, 1'b1);
        ctrl.timer_a_io_route = 2'h1;
        ctrl.uart2_receive_route = 2'h0;
        ctrl.irq0_enable = 1'b1;
        go;
        chk1(analog_sel.comparator1_input, 1'b0);
        chk1(pin_in.ext_irq0_input, 1'b0);
        ctrl = '0;
        ctrl.uart2_transmit_route = 3'h5;
        ctrl.serial_mode_field = 3'h1;
        ctrl.chip_select_pin_mode = 2'h2;
        ctrl.chip_select_open_drain = 1'b1;
        pout.uart2_transmit = 1'b1;
        pout.serial_chip_select_out = 1'b0;
        go;
        chk1(pad_oe_n[10], 1'b0);
        chk1(pad_out[10], 1'b1);
        chk1(pad_oe_n[2], 1'b0);
        pout.serial_chip_select_out = 1'b1;
        go;
        chk1(pad_oe_n[2], 1'b1);
        ctrl = '0;
        ctrl.uart2_handshake_route = 1'b1;
        ctrl.serial_mode_field = 3'h1;
        ctrl.handshake_kind_select = 1'b1;
        ctrl.uart2_clock_route = 2'h3;
        ctrl.uart2_clock_open_drain = 1'b1;
        ctrl.data_open_drain = 1'b1;
        ctrl.bidirectional_mode = 1'b1;
        pout.uart2_request_to_send = 1'b1;
        pout.sdi_out_ctl = 1'b1;
        pout.serial_data_io_out = 1'b1;
        pout.sck_in_ctl = 1'b1;
        go;
        chk1(pad_oe_n[2], 1'b0);
        chk1(pad_out[2], 1'b1);
        chk1(pad_out[3], 1'b1);
        chk1(pad_oe_n[9], 1'b0);
        chk1(pin_in.serial_clock_in, 1'b0);
        ctrl = '0;
        pout = '0;
        ext_en = 11'h250;
        ctrl.irq3_enable = 1'b1;
        ctrl.comparator3_select = 1'b1;
        ctrl.uart1_clock_route = 2'h3;
        ctrl.uart1_clock_direction_bit = 1'b1;
        go;
        chk1(analog_sel.comparator3_input, 1'b1);
        chk1(analog_sel.comparator3_reference, 1'b1);
        chk1(pin_in.uart1_clock_in, 1'b0);
        ctrl.timer_c_ch3_route = 2'h2;
        pout.timer_c_ch3_oe = 1'b1;
        pout.timer_c_ch3_out = 1'b1;
        go;
        chk1(pad_out[3], 1'b1);
        chk1(analog_sel.comparator3_reference, 1'b0);
        stop_test;
    end
endmodule
